// ---- verilog/rsw_defs.svh ----
`ifndef RSW_DEFS_SVH
`define RSW_DEFS_SVH
// ************************************************************
// register offsets and fields
// ************************************************************
`define RSW_ADDR_WD_RELOAD    8'hA6
`define RSW_ADDR_WD_KEY       8'hAE
`define RSW_ADDR_PWR_CTRL     8'h87
`define RSW_ADDR_USB_IEN      8'hB5
`define RSW_ADDR_USB_ISTA     8'hB6
`define RSW_ADDR_RST_CAUSE    8'hF0
`define RSW_BIT_LSR_DISABLE   5
`define RSW_BIT_USB_RST_EN    6
`define RSW_BIT_USB_RST_FLAG  6
`define RSW_WD_KEY_DISABLE    8'h55
`define RSW_RST_PWR_CTRL      8'h00
`define RSW_RST_USB_IEN       8'h00
`define RSW_RST_WD_KEY        8'h00
// ************************************************************
// timing
// ************************************************************
`define RSW_CLK_MHZ           200
`define RSW_WD_BITS           22
`define RSW_WD_PULSE_CYC      32768
`define RSW_LSR_HOLD_MS       10
`define RSW_LSR_HOLD_CYC      (`RSW_LSR_HOLD_MS * 1000 * `RSW_CLK_MHZ)
`define RSW_NOISE_NS          1000
`define RSW_NOISE_CYC         ((`RSW_NOISE_NS * `RSW_CLK_MHZ) / 1000)
`define RSW_EXT_MS            1
`define RSW_EXT_CYC           (`RSW_EXT_MS * 1000 * `RSW_CLK_MHZ)
`define RSW_SE0_MIN           4
`endif

// ---- verilog/rsw_pkg.sv ----
package rsw_pkg;
	typedef logic [7:0] rsw_byte_type;
	typedef enum logic [1:0] {RSW_RUN, RSW_WD_PULSE} rsw_wd_state_type;
endpackage : rsw_pkg

// ---- verilog/rsw_if.sv ----
`timescale 1ns/1ps
// ************************************************************
// cpu side special function register bus
// ************************************************************
interface rsw_if (input wire logic clk);
	logic [7:0] sfr_addr;
	logic [7:0] sfr_wdata;
	logic       sfr_wr;
	logic       sfr_rd;
	logic [7:0] sfr_rdata;
	logic       cpu_reset;
	modport dev (input sfr_addr, input sfr_wdata, input sfr_wr, input sfr_rd, output sfr_rdata, output cpu_reset);
	modport cpu (output sfr_addr, output sfr_wdata, output sfr_wr, output sfr_rd, input sfr_rdata, input cpu_reset);
endinterface : rsw_if

// ---- verilog/rsw_device.sv ----
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`include "rsw_defs.svh"
module rsw_device #(
	parameter int LSR_HOLD_CYC = `RSW_LSR_HOLD_CYC,
	parameter int WD_PULSE_CYC = `RSW_WD_PULSE_CYC
) (
	input  wire logic          clk,
	input  wire logic          reset,
	rsw_if.dev                 bus,
	input  wire logic          ext_reset_n,
	input  wire logic          supply_low,
	input  wire logic          usb_se0,
	input  wire logic          usb_sample,
	output rsw_pkg::rsw_byte_type pwr_ctrl,
	output logic               companion_reset_n
);
	import rsw_pkg::*;
	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [2:0] meta_r;
	logic [2:0] sync_r;
	always_ff @(posedge clk)
	begin
		meta_r <= {ext_reset_n, supply_low, usb_se0};
		sync_r <= meta_r;
	end
	wire ext_n_s  = sync_r[2];
	wire low_s    = sync_r[1];
	wire se0_s    = sync_r[0];
	// ************************************************************
	// registers
	// ************************************************************
	rsw_byte_type pwr_r;
	rsw_byte_type usb_interrupt_enable_register_r;
	rsw_byte_type key_r;
	rsw_byte_type rdata_r;
	logic         usb_flag_r;
	logic [3:0]   cause_r;
	logic         int_reset_r;
	logic         rst_d_r;
	wire wr_reload = bus.sfr_wr && bus.sfr_addr == `RSW_ADDR_WD_RELOAD;
	wire wr_key    = bus.sfr_wr && bus.sfr_addr == `RSW_ADDR_WD_KEY;
	wire wr_pwr    = bus.sfr_wr && bus.sfr_addr == `RSW_ADDR_PWR_CTRL;
	wire wr_usb_interrupt_enable_register   = bus.sfr_wr && bus.sfr_addr == `RSW_ADDR_USB_IEN;
	wire wr_usta   = bus.sfr_wr && bus.sfr_addr == `RSW_ADDR_USB_ISTA;
	// ************************************************************
	// low-supply detector: filter then hold
	// ************************************************************
	// filtering and the hold run on clk, which keeps running in idle and power-down here
	logic [8:0]  noise_r;
	logic        low_ok_r;
	logic [31:0] hold_r;
	wire lsr_en = !pwr_r[`RSW_BIT_LSR_DISABLE];
	// filter and hold restart at reset: the synchroniser is still unknown then
	always_ff @(posedge clk)
	begin
		if (reset || !low_s)
		begin
			noise_r  <= 9'h000;
			low_ok_r <= 1'b0;
		end
		else if (noise_r < 9'(`RSW_NOISE_CYC))
			noise_r <= noise_r + 9'h001;
		else
			low_ok_r <= 1'b1;
	end
	always_ff @(posedge clk)
	begin
		if (reset)
			hold_r <= 32'h0;
		else if (low_ok_r && lsr_en)
			hold_r <= 32'(LSR_HOLD_CYC);
		else if (hold_r != 32'h0)
			hold_r <= hold_r - 32'h1;
	end
	wire lsr_src = (low_ok_r && lsr_en) || hold_r != 32'h0;
	// ************************************************************
	// usb bus reset detection
	// ************************************************************
	logic [2:0] se0_cnt_r;
	wire se0_hit = se0_s && usb_sample && se0_cnt_r == 3'(`RSW_SE0_MIN - 1);
	always_ff @(posedge clk)
	begin
		if (!se0_s)
			se0_cnt_r <= 3'h0;
		else if (usb_sample && se0_cnt_r != 3'h7)
			se0_cnt_r <= se0_cnt_r + 3'h1;
	end
	wire usb_src = se0_hit && usb_interrupt_enable_register_r[`RSW_BIT_USB_RST_EN];
	// ************************************************************
	// watchdog
	// ************************************************************
	logic [`RSW_WD_BITS-1:0] wd_cnt_r;
	logic [15:0]             pulse_r;
	rsw_wd_state_type        wd_state_r;
	wire wd_on    = key_r != `RSW_WD_KEY_DISABLE;
	wire wd_ovf   = wd_on && (&wd_cnt_r);
	wire [6:0] reload_v = bus.sfr_wdata[6:0];
	always_ff @(posedge clk)
	begin
		if (int_reset_r && wd_state_r == RSW_RUN)
			wd_cnt_r <= '0;
		else if (wr_reload)
			wd_cnt_r <= {reload_v, 15'h0000};
		else if (wd_on)
			wd_cnt_r <= wd_cnt_r + 22'h000001;
	end
	always_ff @(posedge clk)
	begin
		if (reset)
			wd_state_r <= RSW_RUN;
		else
			case (wd_state_r)
			RSW_RUN:
				if (wd_ovf)
				begin
					wd_state_r <= RSW_WD_PULSE;
					// overflow cycle plus pulse state give WD_PULSE_CYC cycles
					pulse_r    <= 16'(WD_PULSE_CYC - 2);
				end
			RSW_WD_PULSE:
				if (pulse_r == 16'h0)
					wd_state_r <= RSW_RUN;
				else
					pulse_r <= pulse_r - 16'h1;
			default:
				wd_state_r <= RSW_RUN;
			endcase
	end
	wire wd_src = wd_ovf || wd_state_r == RSW_WD_PULSE;
	// ************************************************************
	// reset merge
	// ************************************************************
	// a one-cycle source still gives two cycles of reset, enough for the cpu to settle
	wire  min_hold = int_reset_r && !rst_d_r;
	wire  any_src  = !ext_n_s || lsr_src || usb_src || wd_src;
	always_ff @(posedge clk)
	begin
		rst_d_r           <= int_reset_r;
		int_reset_r       <= reset || any_src || min_hold;
		companion_reset_n <= !(reset || any_src || min_hold);
	end
	// ************************************************************
	// register file; key and control are cleared by reset and by every internal reset, watchdog included
	// ************************************************************
	always_ff @(posedge clk)
	begin
		if (reset || int_reset_r)
		begin
			key_r  <= `RSW_RST_WD_KEY;
			usb_interrupt_enable_register_r <= `RSW_RST_USB_IEN;
			pwr_r  <= `RSW_RST_PWR_CTRL;
		end
		else
		begin
			if (wr_key)
				key_r <= bus.sfr_wdata;
			if (wr_usb_interrupt_enable_register)
				usb_interrupt_enable_register_r <= bus.sfr_wdata;
			if (wr_pwr)
				pwr_r <= bus.sfr_wdata;
		end
	end
	// flag set wins over software clear (write one to clear)
	always_ff @(posedge clk)
	begin
		if (reset)
			usb_flag_r <= 1'b0;
		else if (se0_hit)
			usb_flag_r <= 1'b1;
		else if (wr_usta && bus.sfr_wdata[`RSW_BIT_USB_RST_FLAG])
			usb_flag_r <= 1'b0;
	end
	// cause bits: ext, supply, usb, watchdog; cleared by a write to the cause register while no source is active
	always_ff @(posedge clk)
	begin
		if (reset)
			cause_r <= 4'h0;
		else if (any_src)
			cause_r <= cause_r | {wd_src, usb_src, lsr_src, !ext_n_s};
		else if (bus.sfr_wr && bus.sfr_addr == `RSW_ADDR_RST_CAUSE)
			cause_r <= 4'h0;
	end
	wire [7:0] rd_mux =
		bus.sfr_addr == `RSW_ADDR_WD_KEY    ? key_r :
		bus.sfr_addr == `RSW_ADDR_PWR_CTRL  ? pwr_r :
		bus.sfr_addr == `RSW_ADDR_USB_IEN   ? usb_interrupt_enable_register_r :
		bus.sfr_addr == `RSW_ADDR_USB_ISTA  ? {1'b0, usb_flag_r, 6'h00} :
		bus.sfr_addr == `RSW_ADDR_RST_CAUSE ? {4'h0, cause_r} : 8'h00;
	always_ff @(posedge clk)
	begin
		if (reset)
			rdata_r <= 8'h00;
		else if (bus.sfr_rd)
			rdata_r <= rd_mux;
		else
			rdata_r <= 8'h00;
	end
	assign bus.sfr_rdata = rdata_r;
	assign bus.cpu_reset = int_reset_r;
	assign pwr_ctrl      = pwr_r;
endmodule : rsw_device

// ---- verilog/rsw_cpu.sv ----
`timescale 1ns/1ps
`include "rsw_defs.svh"
// ************************************************************
// cpu end: registered software port to the register bus; strobes are dropped during internal reset
// ************************************************************
module rsw_cpu (
	input  wire logic          clk,
	input  wire logic          reset,
	rsw_if.cpu                 bus,
	input  wire logic [7:0]    sw_addr,
	input  wire logic [7:0]    sw_wdata,
	input  wire logic          sw_wr,
	input  wire logic          sw_rd,
	output rsw_pkg::rsw_byte_type sw_rdata,
	output logic               sw_in_reset
);
	import rsw_pkg::*;
	logic [7:0] addr_r;
	logic [7:0] wdata_r;
	logic       wr_r;
	logic       rd_r;
	// reload values above 7Eh are clipped so bit 7 never reaches the device
	wire [7:0] wval = (sw_addr == `RSW_ADDR_WD_RELOAD && sw_wdata > 8'h7E) ? 8'h7E : sw_wdata;
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			addr_r  <= 8'h00;
			wdata_r <= 8'h00;
			wr_r    <= 1'b0;
			rd_r    <= 1'b0;
		end
		else
		begin
			addr_r  <= sw_addr;
			wdata_r <= wval;
			wr_r    <= sw_wr && !bus.cpu_reset;
			rd_r    <= sw_rd && !sw_wr && !bus.cpu_reset;
		end
	end
	always_ff @(posedge clk)
	begin
		sw_in_reset <= bus.cpu_reset;
	end
	assign bus.sfr_addr  = addr_r;
	assign bus.sfr_wdata = wdata_r;
	assign bus.sfr_wr    = wr_r;
	assign bus.sfr_rd    = rd_r;
	assign sw_rdata      = bus.sfr_rdata;
endmodule : rsw_cpu

// ---- verif/rsw_chk.sv ----
`timescale 1ns/1ps
// ************************************************************
// register bus and internal reset checks
// ************************************************************
module rsw_chk (
	input wire logic       clk,
	input wire logic       reset,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire logic       cpu_reset
);
	logic [7:0] key_r;
	logic       lsd_r;
	logic       urst_r;
	wire        wr_ok = sfr_wr && !cpu_reset;
	wire        rd_ok = sfr_rd && !cpu_reset;
	// internal reset clears the control registers
	always_ff @(posedge clk)
	begin
		if (reset || cpu_reset)
		begin
			key_r  <= 8'h00;
			lsd_r  <= 1'b0;
			urst_r <= 1'b0;
		end
		else if (wr_ok)
		begin
			key_r  <= (sfr_addr == 8'hAE) ? sfr_wdata : key_r;
			lsd_r  <= (sfr_addr == 8'h87) ? sfr_wdata[5] : lsd_r;
			urst_r <= (sfr_addr == 8'hB5) ? sfr_wdata[6] : urst_r;
		end
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);
	a_key_readback: assert property (rd_ok && sfr_addr == 8'hAE |=> sfr_rdata == key_r)
		else $error("key read back wrong");
	a_pwr_bit: assert property (rd_ok && sfr_addr == 8'h87 |=> sfr_rdata[5] == lsd_r)
		else $error("supply disable bit wrong");
	a_usb_en_bit: assert property (rd_ok && sfr_addr == 8'hB5 |=> sfr_rdata[6] == urst_r)
		else $error("usb reset enable bit wrong");
	a_reload_wo: assert property (rd_ok && sfr_addr == 8'hA6 |=> sfr_rdata == 8'h00)
		else $error("reload register readable");
	a_unmapped_zero: assert property (rd_ok && !(sfr_addr inside {8'h87, 8'hA6, 8'hAE, 8'hB5, 8'hB6, 8'hF0})
		|=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
	a_rdata_idle: assert property (!$past(sfr_rd) |-> sfr_rdata == 8'h00)
		else $error("read data outside a read");
	a_reset_hold: assert property ($fell(reset) |-> cpu_reset)
		else $error("internal reset not held");
	a_reset_min: assert property ($fell(cpu_reset) |-> $past(cpu_reset, 2))
		else $error("internal reset too short");
endmodule : rsw_chk

// ---- verif/rsw_tb.sv ----
`timescale 1ns/1ps
module rsw_tb;
	import rsw_pkg::*;
	logic         clk = 1'b0;
	logic         reset = 1'b1;
	logic [7:0]   sw_addr = 8'h00;
	logic [7:0]   sw_wdata = 8'h00;
	logic         sw_wr = 1'b0;
	logic         sw_rd = 1'b0;
	logic         ext_reset_n = 1'b1;
	logic         supply_low = 1'b0;
	logic         usb_se0 = 1'b0;
	logic         usb_sample = 1'b0;
	rsw_byte_type sw_rdata;
	rsw_byte_type pwr_ctrl;
	logic         sw_in_reset;
	logic         companion_reset_n;
	int           failures = 0;
	int           num_checks = 0;
	int           n;
	always #2.5 clk = ~clk;
	rsw_if bus (.clk(clk));
	// short hold and pulse counts keep the run brief
	rsw_device #(.LSR_HOLD_CYC(50), .WD_PULSE_CYC(16)) i_rsw_device (.clk(clk), .reset(reset), .bus(bus),
		.ext_reset_n(ext_reset_n), .supply_low(supply_low), .usb_se0(usb_se0), .usb_sample(usb_sample),
		.pwr_ctrl(pwr_ctrl), .companion_reset_n(companion_reset_n));
	rsw_cpu i_rsw_cpu (.clk(clk), .reset(reset), .bus(bus), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
		.sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .sw_in_reset(sw_in_reset));
	rsw_chk i_rsw_chk (.clk(clk), .reset(reset), .sfr_addr(bus.sfr_addr), .sfr_wdata(bus.sfr_wdata),
		.sfr_wr(bus.sfr_wr), .sfr_rd(bus.sfr_rd), .sfr_rdata(bus.sfr_rdata), .cpu_reset(bus.cpu_reset));
	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic end_sim();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_sim
	task automatic check(input logic [7:0] exp, input logic [7:0] got, input string what);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge clk);
		sw_wr <= 1'b0;
	endtask : wr
	// data shows two edges after the strobe: one in the cpu end, one in the device
	task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp, input string w);
		@(posedge clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge clk);
		sw_rd <= 1'b0;
		@(posedge clk);
		#1;
		check(exp, sw_rdata & m, w);
	endtask : rdchk
	task automatic wait_rst(input logic lvl, input int lim);
		n = 0;
		while (sw_in_reset !== lvl)
		begin
			if (n == lim)
			begin
				check(lvl, ~lvl, "reset wait");
				end_sim();
			end
			@(posedge clk);
			#1;
			n++;
		end
	endtask : wait_rst
	task automatic samples(input int k);
		repeat (k)
		begin
			@(posedge clk);
			usb_sample <= 1'b1;
			@(posedge clk);
			usb_sample <= 1'b0;
		end
	endtask : samples
	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_regs();
		wr(8'h87, 8'h20);
		rdchk(8'h87, 8'h20, 8'h20, "pwr bit5");
		check(8'h20, pwr_ctrl & 8'h20, "pwr port");
		wr(8'h87, 8'h00);
		rdchk(8'hA6, 8'hFF, 8'h00, "reload read");
		rdchk(8'h10, 8'hFF, 8'h00, "unmapped");
		wr(8'hAE, 8'h55);
		rdchk(8'hAE, 8'hFF, 8'h55, "key");
		$display("t_regs done");
	endtask : t_regs
	task automatic t_ext();
		@(posedge clk);
		ext_reset_n <= 1'b0;
		wait_rst(1'b1, 10);
		check(8'h00, {7'h00, companion_reset_n}, "companion low");
		@(posedge clk);
		ext_reset_n <= 1'b1;
		wait_rst(1'b0, 10);
		check(8'h01, {7'h00, companion_reset_n}, "companion high");
		rdchk(8'hAE, 8'hFF, 8'h00, "key cleared");
		$display("t_ext done");
	endtask : t_ext
	task automatic t_supply();
		@(posedge clk);
		supply_low <= 1'b1;
		repeat (100) @(posedge clk);
		supply_low <= 1'b0;
		repeat (5) @(posedge clk);
		check(8'h00, {7'h00, sw_in_reset}, "short dip");
		supply_low <= 1'b1;
		wait_rst(1'b1, 400);
		check(8'h01, {7'h00, n > 150}, "noise delay");
		@(posedge clk);
		supply_low <= 1'b0;
		wait_rst(1'b0, 200);
		check(8'h01, {7'h00, n >= 50 && n < 60}, "supply hold");
		wr(8'h87, 8'h20);
		supply_low <= 1'b1;
		repeat (400) @(posedge clk);
		check(8'h00, {7'h00, sw_in_reset}, "supply disabled");
		supply_low <= 1'b0;
		wr(8'h87, 8'h00);
		$display("t_supply done");
	endtask : t_supply
	task automatic t_usb();
		usb_se0 <= 1'b1;
		// se0 must pass the synchroniser before the first sample point counts
		repeat (2) @(posedge clk);
		samples(3);
		rdchk(8'hB6, 8'h40, 8'h00, "three samples");
		samples(1);
		rdchk(8'hB6, 8'h40, 8'h40, "four samples");
		check(8'h00, {7'h00, sw_in_reset}, "usb no reset");
		@(posedge clk);
		usb_se0 <= 1'b0;
		wr(8'hB6, 8'h40);
		rdchk(8'hB6, 8'h40, 8'h00, "flag cleared");
		wr(8'hB5, 8'h40);
		rdchk(8'hB5, 8'h40, 8'h40, "usb enable");
		@(posedge clk);
		usb_se0 <= 1'b1;
		repeat (2) @(posedge clk);
		samples(4);
		wait_rst(1'b1, 10);
		@(posedge clk);
		usb_se0 <= 1'b0;
		wait_rst(1'b0, 40);
		rdchk(8'hF0, 8'h0F, 8'h07, "cause bits");
		wr(8'hF0, 8'h00);
		rdchk(8'hF0, 8'h0F, 8'h00, "cause cleared");
		$display("t_usb done");
	endtask : t_usb
	task automatic t_wd();
		// 7E loads 3F0000, leaving 65535 counts to all ones
		wr(8'hA6, 8'h7E);
		repeat (65000) @(posedge clk);
		check(8'h00, {7'h00, sw_in_reset}, "wd early");
		wait_rst(1'b1, 1000);
		wait_rst(1'b0, 40);
		check(8'd16, n[7:0], "wd pulse");
		$display("t_wd done");
	endtask : t_wd
	initial
	begin
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		wait_rst(1'b0, 20);
		t_regs();
		t_ext();
		t_supply();
		t_usb();
		t_wd();
		end_sim();
	end
endmodule : rsw_tb
